// ---- hdl/sfdp_map_pkg.sv ----
// Purpose: Constants, types and encoders for the sector map descriptor content
// Assumes: Byte offsets are relative to the start of the sector map parameter table
// Notes:   Dwords are little endian, so byte 0 of a dword holds bits 7:0

package sfdp_map_pkg;

    // ==========================================================
    // Window of the table held here
    // ==========================================================
    localparam logic [7:0]  MAP_BASE      = 8'h58;
    localparam logic [7:0]  MAP_LAST      = 8'h6f;
    localparam logic [4:0]  BYTE_COUNT    = 5'h18;
    localparam logic [7:0]  UNMAPPED_BYTE = 8'hff;

    // ==========================================================
    // Descriptor field values
    // ==========================================================
    localparam int          DESC_END_BIT      = 0;
    localparam int          DESC_MAP_BIT      = 1;
    localparam int          ERASE_T3_BIT      = 2;
    localparam int          ERASE_T4_BIT      = 3;
    localparam logic [7:0]  OP_READ_ANY_REG   = 8'h65;
    localparam logic [1:0]  ADDR_LEN_VARIABLE = 2'h3;
    localparam logic [1:0]  DETECT_RFU_MID    = 2'h3;
    localparam logic [3:0]  LATENCY_VARIABLE  = 4'hf;
    localparam logic [5:0]  DESC_RFU_LOW      = 6'h3f;
    localparam logic [7:0]  DETECT3_MASK      = 8'h02;
    localparam logic [31:0] DETECT3_REG_ADDR  = 32'h0000_0004;
    localparam logic [7:0]  BOTTOM_REGION_CNT = 8'h02;
    localparam logic [7:0]  BOTTOM_CONFIG_ID  = 8'h00;
    localparam logic [7:0]  HEADER_RFU_HIGH   = 8'hff;
    localparam logic [3:0]  REGION_RFU        = 4'hf;
    localparam logic [23:0] REGION0_SIZE      = 24'h00007f;
    localparam logic [23:0] REGION1_SIZE      = 24'h00007f;
    localparam logic [23:0] REGION2_SIZE      = 24'h007eff;
    localparam logic [3:0]  ERASE_4K_ONLY     = 4'h1;
    localparam logic [3:0]  ERASE_64K_ONLY    = 4'h2;
    localparam int          REGION_UNIT_SHIFT = 8;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_FETCH = 2'b10
    } fetch_state_t;

    typedef struct packed {
        logic [7:0] data;
    } rom_state_t;

    typedef struct packed {
        logic [1:0] regionIndex;
        logic [3:0] eraseMask;
    } lookup_state_t;

    typedef struct packed {
        fetch_state_t state;
        logic [7:0]   reqAddr;
        logic         reqHit;
        logic [7:0]   readData;
        logic         readValid;
        logic         readMiss;
        logic         writeRefused;
    } port_state_t;

    // ==========================================================
    // Encoders
    // ==========================================================
    function automatic logic [31:0] detect_dword(input logic isLast, input logic [7:0] opcode,
                                                 input logic [7:0] mask);
        return {mask, ADDR_LEN_VARIABLE, DETECT_RFU_MID, LATENCY_VARIABLE, opcode,
                DESC_RFU_LOW, 1'b0, isLast};
    endfunction : detect_dword

    function automatic logic [31:0] header_dword(input logic isLast, input logic [7:0] configId,
                                                 input logic [7:0] regionCount);
        return {HEADER_RFU_HIGH, regionCount, configId, DESC_RFU_LOW, 1'b1, isLast};
    endfunction : header_dword

    function automatic logic [31:0] region_dword(input logic [23:0] size, input logic [3:0] erase);
        return {size, REGION_RFU, erase};
    endfunction : region_dword

    // Byte length of a region from its count-minus-one code
    function automatic logic [31:0] region_bytes(input logic [23:0] size);
        return ({8'h00, size} + 32'h1) << REGION_UNIT_SHIFT;
    endfunction : region_bytes

endpackage : sfdp_map_pkg

// ---- hdl/rom_port_if.sv ----
// Purpose: Byte read port between the request logic and the descriptor store
// Assumes: Data is valid the cycle after readEn
// Notes:   None
`timescale 1ns/10ps

interface rom_port_if;
    logic       readEn;
    logic [4:0] byteIndex;
    logic [7:0] data;

    modport requester (output readEn, output byteIndex, input data);
    modport memory    (input readEn, input byteIndex, output data);
endinterface : rom_port_if

// ---- hdl/sector_map_store.sv ----
// Purpose: Fixed descriptor bytes with registered read data
// Assumes: Index counts bytes from the start of the held window
// Notes:   No write path exists at all
`timescale 1ns/10ps

module sector_map_store (
    input  wire logic clk,
    input  wire logic rst,
    rom_port_if.memory port
);
    import sfdp_map_pkg::*;

    rom_state_t cur;
    rom_state_t next_cur;

    function automatic logic [31:0] table_word(input logic [2:0] idx);
        unique case (idx)
            3'd0:    return detect_dword(1'b1, OP_READ_ANY_REG, DETECT3_MASK); // R01 R02 R03 R04
            3'd1:    return DETECT3_REG_ADDR; // R05
            3'd2:    return header_dword(1'b0, BOTTOM_CONFIG_ID, BOTTOM_REGION_CNT); // R07 R08 R09 R16
            3'd3:    return region_dword(REGION0_SIZE, ERASE_4K_ONLY); // R10 R12 R14 R15
            3'd4:    return region_dword(REGION1_SIZE, ERASE_64K_ONLY); // R11 R13 R14 R15
            3'd5:    return region_dword(REGION2_SIZE, ERASE_64K_ONLY); // R17
            default: return {4{UNMAPPED_BYTE}};
        endcase
    endfunction : table_word

    always_comb begin
        logic [31:0] word;
        word     = table_word(port.byteIndex[4:2]);
        next_cur = cur;
        if (port.readEn) begin
            next_cur.data = word[{port.byteIndex[1:0], 3'b000} +: 8];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign port.data = cur.data;
endmodule : sector_map_store

// ---- hdl/region_lookup.sv ----
// Purpose: Maps a flash byte address to its bottom-boot region and erase types
// Assumes: 23-bit byte address for the 8 MB array
// Notes:   Bounds derive from the same size codes the table reports
`timescale 1ns/10ps

module region_lookup (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [22:0] probeAddr,
    output logic      [1:0]  regionIndex,
    output logic      [3:0]  eraseMask
);
    import sfdp_map_pkg::*;

    localparam logic [31:0] END0 = region_bytes(REGION0_SIZE);
    localparam logic [31:0] END1 = END0 + region_bytes(REGION1_SIZE);

    lookup_state_t cur;
    lookup_state_t next_cur;

    always_comb begin
        logic [31:0] addr;
        addr     = {9'h000, probeAddr};
        next_cur = cur;
        if (addr < END0) begin
            next_cur.regionIndex = 2'd0;
            next_cur.eraseMask   = ERASE_4K_ONLY; // R12
        end else if (addr < END1) begin
            next_cur.regionIndex = 2'd1;
            next_cur.eraseMask   = ERASE_64K_ONLY; // R13
        end else begin
            next_cur.regionIndex = 2'd2;
            next_cur.eraseMask   = ERASE_64K_ONLY; // R17
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign regionIndex = cur.regionIndex;
    assign eraseMask   = cur.eraseMask;
endmodule : region_lookup

// ---- hdl/sector_map_descriptor_rom.sv ----
// Purpose: Read-only sector map descriptor bytes served to the host controller
// Assumes: Requests are one-cycle pulses synchronous to clk
// Notes:   Unmapped offsets read as all ones and raise readMiss
//
// What this block does
// R01: Third detection descriptor names read-any-register opcode as its probe instruction.
// R02: Detection descriptor encodes variable address length and variable latency.
// R03: Third detection descriptor sets bit 0, marking the last detection entry.
// R04: Detection descriptors clear bit 1, marking a command descriptor.
// R05: Probe target address is register four, the nonvolatile config register three.
// R06: Host reads masked bit zero as 64KB uniform, one as 256KB.
// R07: Bottom-boot header reports region count two, meaning three regions.
// R08: Bottom-boot header carries configuration identifier zero.
// R09: Map header sets bit 1 and clears bit 0.
// R10: Region sizes are 256-byte units minus one; region zero encodes 7Fh.
// R11: Region one, a single 32KB sector, also encodes 7Fh.
// R12: Region zero flags only 4KB erase as supported.
// R13: Region one flags only 64KB erase as supported.
// R14: 256KB erase is unsupported in the small-sector regions.
// R15: Erase type four flag reads zero in every region.
// R16: Header upper byte and region bits 7:4 read all ones.
// R17: Final region covers 127 sectors of 64KB, size code 7EFFh.
// R18: Content is fixed; host writes leave read values unchanged.
`timescale 1ns/10ps

module sector_map_descriptor_rom (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        readReq,
    input  wire logic [7:0]  readAddr,
    input  wire logic        writeReq,
    input  wire logic [7:0]  writeAddr,
    input  wire logic [7:0]  writeData,
    output logic      [7:0]  readData,
    output logic             readValid,
    output logic             readMiss,
    output logic             readBusy,
    output logic             writeRefused,
    input  wire logic [22:0] probeAddr,
    output logic      [1:0]  regionIndex,
    output logic      [3:0]  eraseMask
);
    import sfdp_map_pkg::*;

    // ==========================================================
    // Store and region lookup
    // ==========================================================
    rom_port_if romPort ();

    sector_map_store store (
        .clk  (clk),
        .rst  (rst),
        .port (romPort.memory)
    );

    region_lookup lookup (
        .clk         (clk),
        .rst         (rst),
        .probeAddr   (probeAddr),
        .regionIndex (regionIndex),
        .eraseMask   (eraseMask)
    );

    // ==========================================================
    // Request handling
    // ==========================================================
    port_state_t cur;
    port_state_t next_cur;

    logic       accept;
    logic       inWindow;
    logic [7:0] offset;

    assign readBusy = (cur.state == ST_FETCH);
    assign accept   = readReq && !readBusy;
    assign inWindow = (readAddr >= MAP_BASE) && (readAddr <= MAP_LAST);
    assign offset   = readAddr - MAP_BASE;

    // Store is clocked on the accept edge so data is ready in the fetch cycle
    assign romPort.readEn    = accept && inWindow;
    assign romPort.byteIndex = offset[4:0];

    always_comb begin
        next_cur              = cur;
        next_cur.readValid    = 1'b0;
        next_cur.readMiss     = 1'b0;
        // Writes have no path into the store; they are only acknowledged as refused
        next_cur.writeRefused = writeReq; // R18
        unique case (cur.state)
            ST_IDLE: begin
                if (accept) begin
                    next_cur.state   = ST_FETCH;
                    next_cur.reqAddr = readAddr;
                    next_cur.reqHit  = inWindow;
                end
            end
            ST_FETCH: begin
                next_cur.state     = ST_IDLE;
                next_cur.readValid = 1'b1;
                next_cur.readMiss  = !cur.reqHit;
                next_cur.readData  = cur.reqHit ? romPort.data : UNMAPPED_BYTE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur          <= '0;
            cur.state    <= ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    assign readData     = cur.readData;
    assign readValid    = cur.readValid;
    assign readMiss     = cur.readMiss;
    assign writeRefused = cur.writeRefused;

    // ==========================================================
    // Assertions
    // ==========================================================
    a_read_latency: assert property (@(posedge clk) disable iff (rst)
        accept |-> ##2 readValid)
        else $error("read answer not two cycles after accept");

    a_detect_opcode: assert property (@(posedge clk) disable iff (rst) // R01
        (accept && readAddr == MAP_BASE + 8'h01) |-> ##2 (readData == OP_READ_ANY_REG))
        else $error("probe opcode byte wrong");

    a_detect_variable: assert property (@(posedge clk) disable iff (rst) // R02
        (accept && readAddr == MAP_BASE + 8'h02) |-> ##2
        (readData == {ADDR_LEN_VARIABLE, DETECT_RFU_MID, LATENCY_VARIABLE}))
        else $error("address length or latency not variable");

    a_detect_flags: assert property (@(posedge clk) disable iff (rst) // R03
        (accept && readAddr == MAP_BASE) |-> ##2
        (readData[DESC_END_BIT] && !readData[DESC_MAP_BIT])) // R04
        else $error("detection descriptor flags wrong");

    a_probe_addr: assert property (@(posedge clk) disable iff (rst) // R05
        (accept && readAddr == MAP_BASE + 8'h04) |-> ##2 (readData == DETECT3_REG_ADDR[7:0]))
        else $error("probe register address wrong");

    a_header_count: assert property (@(posedge clk) disable iff (rst) // R07
        (accept && readAddr == MAP_BASE + 8'h0a) |-> ##2 (readData == BOTTOM_REGION_CNT))
        else $error("region count wrong");

    a_header_id: assert property (@(posedge clk) disable iff (rst) // R08
        (accept && readAddr == MAP_BASE + 8'h09) |-> ##2 (readData == BOTTOM_CONFIG_ID))
        else $error("configuration id wrong");

    a_header_flags: assert property (@(posedge clk) disable iff (rst) // R09
        (accept && readAddr == MAP_BASE + 8'h08) |-> ##2
        (readData[DESC_MAP_BIT] && !readData[DESC_END_BIT]))
        else $error("map header flags wrong");

    a_region_sizes: assert property (@(posedge clk) disable iff (rst) // R10
        (accept && (readAddr == MAP_BASE + 8'h0d || readAddr == MAP_BASE + 8'h11)) |-> ##2
        (readData == REGION0_SIZE[7:0] && readData == REGION1_SIZE[7:0])) // R11
        else $error("small region size code wrong");

    a_region0_erase: assert property (@(posedge clk) disable iff (rst) // R12
        (accept && readAddr == MAP_BASE + 8'h0c) |-> ##2 (readData[3:0] == ERASE_4K_ONLY))
        else $error("region zero erase flags wrong");

    a_region1_erase: assert property (@(posedge clk) disable iff (rst) // R13
        (accept && readAddr == MAP_BASE + 8'h10) |-> ##2 (readData[3:0] == ERASE_64K_ONLY))
        else $error("region one erase flags wrong");

    a_erase_unsup: assert property (@(posedge clk) disable iff (rst) // R14
        (accept && (readAddr == MAP_BASE + 8'h0c || readAddr == MAP_BASE + 8'h10
                    || readAddr == MAP_BASE + 8'h14)) |-> ##2
        (!readData[ERASE_T3_BIT] && !readData[ERASE_T4_BIT] && readData[7:4] == REGION_RFU)) // R15 R16
        else $error("region flag byte wrong");

    a_header_rfu: assert property (@(posedge clk) disable iff (rst) // R16
        (accept && readAddr == MAP_BASE + 8'h0b) |-> ##2 (readData == HEADER_RFU_HIGH))
        else $error("header reserved byte not all ones");

    a_final_region: assert property (@(posedge clk) disable iff (rst) // R17
        (accept && readAddr == MAP_BASE + 8'h15) |-> ##2 (readData == REGION2_SIZE[7:0]))
        else $error("final region size low byte wrong");

    a_write_refused: assert property (@(posedge clk) disable iff (rst) // R18
        // A read answer may legally land in the busy cycle, so only idle writes are held to stable data
        (writeReq && !readBusy) |=> (writeRefused && $stable(readData)))
        else $error("write not refused or data disturbed");

    a_miss_value: assert property (@(posedge clk) disable iff (rst)
        (accept && !inWindow) |-> ##2 (readMiss && readData == UNMAPPED_BYTE))
        else $error("unmapped read not flagged");

    // Write operands are deliberately unused beyond refusal
    logic unusedWrite;
    assign unusedWrite = ^{writeAddr, writeData};
endmodule : sector_map_descriptor_rom

// ---- testbench/map_host_model.sv ----
// Purpose: Host controller model that fetches descriptor bytes one at a time
// Assumes: Requests launch at the falling edge; answer comes within a few cycles
// Notes:   A released offset shows the inverse of the last one, never a stale copy
`timescale 1ns/10ps

module map_host_model (
    input  wire logic       clk,
    input  wire logic       readValid,
    input  wire logic       readMiss,
    input  wire logic [7:0] readData,
    output logic            readReq,
    output logic      [7:0] readAddr
);
    initial begin
        readReq  = 1'b0;
        readAddr = 8'h00;
    end

    // ==========================================================
    // Request driving
    // ==========================================================
    task automatic drive(input logic req, input logic [7:0] addr);
        @(negedge clk);
        readReq  = req;
        readAddr = req ? addr : ~readAddr;
    endtask : drive

    // Bounded wait, so a dead port reports instead of hanging
    task automatic fetch(input logic [7:0] addr, output logic [7:0] data, output logic miss,
                         output logic ok);
        ok   = 1'b0;
        data = 8'h00;
        miss = 1'b0;
        drive(1'b1, addr);
        drive(1'b0, 8'h00);
        for (int n = 0; n < 6 && !ok; n++) begin
            if (readValid === 1'b1) begin
                ok   = 1'b1;
                data = readData;
                miss = readMiss;
            end else begin
                @(negedge clk);
            end
        end
    endtask : fetch

    // ==========================================================
    // Probe result decoding
    // ==========================================================
    function automatic int uniform_sector_kb(input logic maskedBit);
        return maskedBit ? 256 : 64;
    endfunction : uniform_sector_kb

endmodule : map_host_model

// ---- testbench/sector_map_descriptor_rom_bench.sv ----
// Purpose: Self-checking bench for the sector map descriptor store
// Assumes: Inputs change at the falling edge; reset held five cycles
// Notes:   Expected bytes are rebuilt here from the descriptor fields
`timescale 1ns/10ps

module sector_map_descriptor_rom_bench;
    import sfdp_map_pkg::*;

    localparam int REG0_END = (32'h7f + 1) * 256;
    localparam int REG1_END = REG0_END + (32'h7f + 1) * 256;

    logic        clk;
    logic        rst;
    logic        readReq;
    logic [7:0]  readAddr;
    logic        writeReq;
    logic [7:0]  writeAddr;
    logic [7:0]  writeData;
    logic [7:0]  readData;
    logic        readValid;
    logic        readMiss;
    logic        readBusy;
    logic        writeRefused;
    logic [22:0] probeAddr;
    logic [1:0]  regionIndex;
    logic [3:0]  eraseMask;
    logic [7:0]  expTable [24];
    int          failCount;
    int          cmpCount;

    sector_map_descriptor_rom sector_map_descriptor_rom_i (
        .clk(clk), .rst(rst), .readReq(readReq), .readAddr(readAddr), .writeReq(writeReq),
        .writeAddr(writeAddr), .writeData(writeData), .readData(readData), .readValid(readValid),
        .readMiss(readMiss), .readBusy(readBusy), .writeRefused(writeRefused),
        .probeAddr(probeAddr), .regionIndex(regionIndex), .eraseMask(eraseMask));

    map_host_model map_host_model_i (
        .clk(clk), .readValid(readValid), .readMiss(readMiss), .readData(readData),
        .readReq(readReq), .readAddr(readAddr));

    always #4 clk = ~clk;

    // ==========================================================
    // Compare and report
    // ==========================================================
    task automatic check_value(input logic [7:0] act, input logic [7:0] exp);
        cmpCount++;
        if (act !== exp) begin
            failCount++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check_value

    task automatic check_flag(input logic act, input logic exp);
        check_value({7'h00, act}, {7'h00, exp});
    endtask : check_flag

    task automatic summarize();
        $display("Mismatches %0d, comparisons %0d", failCount, cmpCount);
        if (failCount == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic put_dword(input int idx, input logic [31:0] dw);
        for (int b = 0; b < 4; b++) begin
            expTable[idx * 4 + b] = dw[8 * b +: 8];
        end
    endtask : put_dword

    task automatic fetch_check(input logic [7:0] addr, input logic [7:0] exp, input logic expMiss);
        logic [7:0] d;
        logic       m;
        logic       ok;
        map_host_model_i.fetch(addr, d, m, ok);
        check_flag(ok, 1'b1);
        check_value(d, exp);
        check_flag(m, expMiss);
    endtask : fetch_check

    task automatic check_dword(input int idx);
        for (int b = 0; b < 4; b++) begin
            fetch_check(MAP_BASE + 8'(idx * 4 + b), expTable[idx * 4 + b], 1'b0);
        end
    endtask : check_dword

    task automatic probe(input logic [22:0] addr, input logic [1:0] expIdx, input logic [3:0] expMask);
        @(negedge clk);
        probeAddr = addr;
        @(negedge clk);
        check_value({6'h00, regionIndex}, {6'h00, expIdx});
        check_value({4'h0, eraseMask}, {4'h0, expMask});
    endtask : probe

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_reset();
        check_flag(readValid, 1'b0);
        check_flag(readMiss, 1'b0);
        check_flag(readBusy, 1'b0);
        check_flag(writeRefused, 1'b0);
        check_value(readData, 8'h00);
        check_value({6'h00, regionIndex}, 8'h00);
        check_value({4'h0, eraseMask}, 8'h00);
    endtask : test_reset

    task automatic test_table();
        check_dword(0);
        check_dword(1);
        check_dword(2);
        check_dword(3);
        check_dword(4);
        check_dword(5);
        fetch_check(MAP_BASE - 8'h01, UNMAPPED_BYTE, 1'b1);
        fetch_check(MAP_LAST + 8'h01, UNMAPPED_BYTE, 1'b1);
        check_value(8'(map_host_model_i.uniform_sector_kb(1'b0) / 4), 8'h10);
        check_value(8'(map_host_model_i.uniform_sector_kb(1'b1) / 4), 8'h40);
    endtask : test_table

    // Second request lands in the busy cycle and must vanish
    task automatic test_busy();
        int         valids;
        logic [7:0] d;
        valids = 0;
        d      = 8'h00;
        map_host_model_i.drive(1'b1, 8'h59);
        map_host_model_i.drive(1'b1, 8'h5b);
        check_flag(readBusy, 1'b1);
        map_host_model_i.drive(1'b0, 8'h00);
        for (int n = 0; n < 6; n++) begin
            if (readValid === 1'b1) begin
                valids++;
                d = readData;
            end
            @(negedge clk);
        end
        check_value(8'(valids), 8'h01);
        check_value(d, OP_READ_ANY_REG);
    endtask : test_busy

    task automatic test_write();
        for (int i = 0; i < 24; i++) begin
            @(negedge clk);
            if (i > 0) check_flag(writeRefused, 1'b1);
            writeReq  = 1'b1;
            writeAddr = MAP_BASE + 8'(i);
            writeData = ~expTable[i];
        end
        @(negedge clk);
        writeReq = 1'b0;
        check_flag(writeRefused, 1'b1);
        @(negedge clk);
        check_flag(writeRefused, 1'b0);
        for (int i = 0; i < 24; i++) begin
            fetch_check(MAP_BASE + 8'(i), expTable[i], 1'b0);
        end
    endtask : test_write

    task automatic test_regions();
        probe(23'h0, 2'd0, 4'h1);
        probe(23'(REG0_END - 1), 2'd0, 4'h1);
        probe(23'(REG0_END), 2'd1, 4'h2);
        probe(23'(REG1_END - 1), 2'd1, 4'h2);
        probe(23'(REG1_END), 2'd2, 4'h2);
        probe(23'h7fffff, 2'd2, 4'h2);
    endtask : test_regions

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        clk       = 1'b0;
        rst       = 1'b1;
        writeReq  = 1'b0;
        writeAddr = 8'h00;
        writeData = 8'h00;
        probeAddr = 23'h0;
        failCount = 0;
        cmpCount  = 0;
        put_dword(0, {DETECT3_MASK, 2'b11, 2'b11, 4'b1111, 8'h65, 6'h3f, 1'b0, 1'b1});
        put_dword(1, 32'h0000_0004);
        put_dword(2, {8'hff, 8'h02, 8'h00, 6'h3f, 1'b1, 1'b0});
        put_dword(3, {24'h00007f, 4'hf, 4'b0001});
        put_dword(4, {24'h00007f, 4'hf, 4'b0010});
        put_dword(5, {24'h007eff, 4'hf, 4'b0010});
        repeat (5) @(negedge clk);
        rst = 1'b0;
        test_reset();
        test_table();
        test_busy();
        test_write();
        test_regions();
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failCount++;
        summarize();
    end

endmodule : sector_map_descriptor_rom_bench
